// >>> common/lpddr_core_params.svh
`ifndef LPDDR_CORE_PARAMS_SVH
`define LPDDR_CORE_PARAMS_SVH

// wishbone register byte offsets
`define WB_CTRL_OFS 4'h0
`define WB_STAT_OFS 4'h4
`define WB_MODE_OFS 4'h8
`define WB_EXT_OFS 4'hc

// control register fields
`define CTRL_DEEP_EN_BIT 0
`define CTRL_TEMP_LSB 1
`define CTRL_RESET 8'h00

// status register fields
`define STAT_BANK_LSB 0
`define STAT_RD_BIT 4
`define STAT_WR_BIT 5
`define STAT_STATE_LSB 6
`define STAT_LOST_BIT 8
`define STAT_REFROW_LSB 16

// configuration word fields (loaded from the address lines)
`define MODE_BL_LSB 0
`define MODE_ORDER_BIT 3
`define MODE_CL_LSB 4
`define MODE_RESET 12'h032
`define EXT_AREA_LSB 0
`define EXT_DRIVE_LSB 5
`define EXT_RESET 12'h000
`define CFG_MODE_BANK 2'h0
`define CFG_EXT_BANK 2'h2

// command address fields
`define AP_BIT 10
`define COL_BITS 9
`define ROW_BITS 12

// timing
`define SYS_CLK_MHZ 200
`define SR_PERIOD_NS 15600
`define SR_BASE_CYC ((`SR_PERIOD_NS * `SYS_CLK_MHZ) / 1000)

`endif

// >>> common/lpddr_core_pkg.sv
package lpddr_core_pkg;

  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [1:0] bank;
    logic [11:0] addr;
  } cmdPins_t;

  typedef struct packed {
    logic [15:0] dq;
    logic [1:0] mask;
    logic [1:0] strobe;
  } dataPins_t;

  typedef struct packed {
    logic active;
    logic autoPre;
    logic [1:0] bank;
    logic [11:0] row;
    logic [8:0] col;
  } burst_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SELFREF = 2'b01,
    ST_DEEP = 2'b10
  } devState_t;

endpackage

// >>> design/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncNow,
  output logic [WIDTH-1:0] syncPrev
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      syncNow <= '0;
      syncPrev <= '0;
    end else begin
      meta_q <= pinIn;
      syncNow <= meta_q;
      syncPrev <= syncNow;
    end
  end

endmodule

// >>> design/lpddr_core.sv
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`include "lpddr_core_params.svh"

module lpddr_core import lpddr_core_pkg::*; #(
  parameter int MEM_BITS = 23,
  parameter int SR_BASE = `SR_BASE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic timingPairT,
  input wire logic timingPairC,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankSelect,
  input wire logic [11:0] addr,
  input wire logic [15:0] dqIn,
  output logic [15:0] dqOut,
  output logic dqOeN,
  input wire logic lowerByteStrobeIn,
  input wire logic upperByteStrobeIn,
  output logic lowerByteStrobeOut,
  output logic upperByteStrobeOut,
  output logic lowerByteStrobeOeN,
  output logic upperByteStrobeOeN,
  input wire logic lowerWriteMask,
  input wire logic upperWriteMask,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic [2:0] outputDriveStrength
);

  localparam int DEPTH = 1 << MEM_BITS;

  // two byte lanes per word so each strobe/mask pair owns its byte
  logic [1:0][7:0] memArr [DEPTH];

  cmdPins_t cmdRaw;
  cmdPins_t cmdNow;
  dataPins_t dataRaw;
  dataPins_t dataNow;
  dataPins_t dataPrev;
  logic [1:0] tpNow;
  logic [1:0] tpPrev;

  devState_t state_q;
  logic [11:0] modeReg_q;
  logic [11:0] extReg_q;
  logic [7:0] ctrl_q;
  logic contentLost_q;
  logic [3:0] bankOpen_q;
  logic [11:0] openRow_q [4];
  burst_t rd_q;
  burst_t wr_q;
  logic [3:0] rdIdx_q;
  logic [2:0] rdWait_q;
  logic [3:0] wrIdx_q [2];
  logic [13:0] refRow_q;
  logic [15:0] srCnt_q;
  logic strobeOut_q;
  logic strobeOeN_q;

  function automatic logic [8:0] burstCol(input logic [8:0] start, input logic [3:0] idx,
                                          input logic [2:0] code, input logic inter);
    logic [8:0] msk;
    logic [8:0] step;
    msk = 9'((9'h1 << code) - 9'h1);
    step = inter ? (start ^ {5'h0, idx}) : 9'(start + {5'h0, idx});
    burstCol = (start & ~msk) | (step & msk);
  endfunction

  function automatic logic [MEM_BITS-1:0] memIndex(input logic [1:0] bank,
                                                   input logic [11:0] row,
                                                   input logic [8:0] col);
    memIndex = MEM_BITS'({bank, row, col});
  endfunction

  function automatic logic [13:0] nextRefRow(input logic [13:0] cur, input logic [2:0] area);
    logic [2:0] sh;
    sh = (area > 3'h4) ? 3'h4 : area;
    nextRefRow = 14'(cur + 14'h1) & (14'h3fff >> sh);
  endfunction

  function automatic logic legalMode(input logic [11:0] v);
    legalMode = (v[`MODE_BL_LSB +: 3] inside {3'h1, 3'h2, 3'h3}) &&
                (v[`MODE_CL_LSB +: 3] inside {3'h2, 3'h3});
  endfunction

  assign cmdRaw = {cke, csN, rasN, casN, weN, bankSelect, addr};
  assign dataRaw = {dqIn, upperWriteMask, lowerWriteMask, upperByteStrobeIn, lowerByteStrobeIn};

  pin_sync #(.WIDTH(19)) uCmdSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pinIn(cmdRaw),
    .syncNow(cmdNow),
    .syncPrev()
  );

  pin_sync #(.WIDTH(20)) uDataSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pinIn(dataRaw),
    .syncNow(dataNow),
    .syncPrev(dataPrev)
  );

  pin_sync #(.WIDTH(2)) uPairSync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pinIn({timingPairT, timingPairC}),
    .syncNow(tpNow),
    .syncPrev(tpPrev)
  );

  wire tpRise = tpNow[1] & ~tpPrev[1] & ~tpNow[0];
  wire tpFall = ~tpNow[1] & tpPrev[1] & tpNow[0];
  // a stopped pair gives no edges, so no read burst advances
  wire tpEdge = tpRise | tpFall;

  wire [2:0] rcw = {cmdNow.rasN, cmdNow.casN, cmdNow.weN};
  wire cmdSel = tpRise & ~cmdNow.csN & (state_q == ST_RUN);
  wire cmdLive = cmdSel & cmdNow.cke;
  wire isCfg = cmdLive & (rcw == 3'b000);
  wire isRef = cmdLive & (rcw == 3'b001);
  wire isPre = cmdLive & (rcw == 3'b010);
  wire isAct = cmdLive & (rcw == 3'b011);
  wire isWr = cmdLive & (rcw == 3'b100);
  wire isRd = cmdLive & (rcw == 3'b101);
  wire isBst = cmdLive & (rcw == 3'b110);
  wire srEnter = cmdSel & ~cmdNow.cke & (rcw == 3'b001);
  wire deepEnter = cmdSel & ~cmdNow.cke & (rcw == 3'b110) & ctrl_q[`CTRL_DEEP_EN_BIT];

  // length and order from the mode word
  wire [2:0] blCode = modeReg_q[`MODE_BL_LSB +: 3];
  wire inter = modeReg_q[`MODE_ORDER_BIT];
  wire [3:0] burstLen = 4'(4'h1 << blCode);
  // latency counted in pair half cycles
  wire [2:0] clCode = modeReg_q[`MODE_CL_LSB +: 3];
  wire [2:0] rdWaitInit = 3'({clCode, 1'b0} - 4'h1);
  wire [2:0] areaCode = extReg_q[`EXT_AREA_LSB +: 3];
  wire [1:0] tempCode = ctrl_q[`CTRL_TEMP_LSB +: 2];

  // bank, start column and auto precharge flag
  burst_t newBurst;
  assign newBurst = '{active: 1'b1, autoPre: cmdNow.addr[`AP_BIT], bank: cmdNow.bank,
                      row: openRow_q[cmdNow.bank], col: cmdNow.addr[`COL_BITS-1:0]};

  // addresses walk by order, no further commands
  wire [MEM_BITS-1:0] rdAddr = memIndex(rd_q.bank, rd_q.row,
                                        burstCol(rd_q.col, rdIdx_q, blCode, inter));
  wire [MEM_BITS-1:0] wrAddrLo = memIndex(wr_q.bank, wr_q.row,
                                          burstCol(wr_q.col, wrIdx_q[0], blCode, inter));
  wire [MEM_BITS-1:0] wrAddrHi = memIndex(wr_q.bank, wr_q.row,
                                          burstCol(wr_q.col, wrIdx_q[1], blCode, inter));

  // each lane clocked by its own strobe
  wire [1:0] strobeEdge = dataNow.strobe ^ dataPrev.strobe;
  wire [1:0] laneTake = {wr_q.active & strobeEdge[1] & (wrIdx_q[1] != burstLen),
                         wr_q.active & strobeEdge[0] & (wrIdx_q[0] != burstLen)};
  wire wrDone = wr_q.active & (wrIdx_q[0] == burstLen) & (wrIdx_q[1] == burstLen);

  wire rdDrive = tpEdge & rd_q.active & (rdWait_q == 3'h0);
  wire rdPre = tpEdge & rd_q.active & (rdWait_q == 3'h1);
  wire rdLast = rdDrive & (rdIdx_q == 4'(burstLen - 4'h1));
  wire rdEndAp = rdLast & rd_q.autoPre & ~isRd & ~isWr;
  wire wrEndAp = wrDone & wr_q.autoPre & ~isRd & ~isWr;

  wire [15:0] srInterval = 16'(SR_BASE * (32'(tempCode) + 1));

  wire wbReq = wbCyc & wbStb & ~wbAck;
  wire ctrlHit = (wbAdr == `WB_CTRL_OFS);
  wire statHit = (wbAdr == `WB_STAT_OFS);
  wire modeHit = (wbAdr == `WB_MODE_OFS);
  wire extHit = (wbAdr == `WB_EXT_OFS);
  wire [31:0] statWord = {2'h0, refRow_q, 7'h0, contentLost_q, state_q,
                          wr_q.active, rd_q.active, bankOpen_q};
  wire [31:0] wbRdData = ctrlHit ? {24'h0, ctrl_q} :
                         statHit ? statWord :
                         modeHit ? {20'h0, modeReg_q} :
                         extHit ? {20'h0, extReg_q} : 32'h0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0;
      ctrl_q <= `CTRL_RESET;
    end else begin
      wbAck <= wbReq;
      if (wbReq) begin
        wbDatO <= wbRdData;
      end
      if (wbReq && wbWe && ctrlHit && wbSel[0]) begin
        ctrl_q <= wbDatI[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_RUN;
      contentLost_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (deepEnter) begin
            state_q <= ST_DEEP;
          end else if (srEnter) begin
            state_q <= ST_SELFREF;
          end
          // reinit clears the lost mark
          if (isCfg) begin
            contentLost_q <= 1'b0;
          end
        end
        ST_SELFREF: begin
          // exit needs no pair edge
          if (cmdNow.cke) begin
            state_q <= ST_RUN;
          end
        end
        ST_DEEP: begin
          if (cmdNow.cke) begin
            state_q <= ST_RUN;
            contentLost_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      modeReg_q <= `MODE_RESET;
      extReg_q <= `EXT_RESET;
      outputDriveStrength <= 3'h0;
    end else if (isCfg) begin
      if (cmdNow.bank == `CFG_MODE_BANK && legalMode(cmdNow.addr)) begin
        modeReg_q <= cmdNow.addr;
      end
      if (cmdNow.bank == `CFG_EXT_BANK) begin
        extReg_q <= cmdNow.addr;
        outputDriveStrength <= cmdNow.addr[`EXT_DRIVE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bankOpen_q <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        openRow_q[b] <= 12'h000;
      end
    end else begin
      if (rdEndAp) begin
        bankOpen_q[rd_q.bank] <= 1'b0;
      end
      if (wrEndAp) begin
        bankOpen_q[wr_q.bank] <= 1'b0;
      end
      // scope bit picks one or all
      if (isPre) begin
        if (cmdNow.addr[`AP_BIT]) begin
          bankOpen_q <= 4'h0;
        end else begin
          bankOpen_q[cmdNow.bank] <= 1'b0;
        end
      end
      if (isAct) begin
        bankOpen_q[cmdNow.bank] <= 1'b1;
        openRow_q[cmdNow.bank] <= cmdNow.addr;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= '0;
      rdIdx_q <= 4'h0;
      rdWait_q <= 3'h0;
    end else if (isRd) begin
      rd_q <= newBurst;
      rdIdx_q <= 4'h0;
      rdWait_q <= rdWaitInit;
    end else if (isWr || (isBst && !rd_q.autoPre) || state_q != ST_RUN) begin
      rd_q.active <= 1'b0;
    end else if (rdDrive) begin
      rdIdx_q <= 4'(rdIdx_q + 4'h1);
      if (rdLast) begin
        rd_q.active <= 1'b0;
      end
    end else if (tpEdge && rd_q.active) begin
      rdWait_q <= 3'(rdWait_q - 3'h1);
    end
  end

  // one word per pair edge, strobe edge aligned
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dqOut <= 16'h0000;
      dqOeN <= 1'b1;
      strobeOut_q <= 1'b0;
      strobeOeN_q <= 1'b1;
    end else if (rdDrive && !isRd && !isWr) begin
      dqOut <= memArr[rdAddr];
      dqOeN <= 1'b0;
      strobeOut_q <= tpRise;
      strobeOeN_q <= 1'b0;
    end else if (rdPre && !isRd && !isWr) begin
      // preamble holds the strobe low
      strobeOut_q <= 1'b0;
      strobeOeN_q <= 1'b0;
    end else if (tpEdge || state_q != ST_RUN) begin
      dqOeN <= 1'b1;
      strobeOut_q <= 1'b0;
      strobeOeN_q <= 1'b1;
    end
  end

  assign lowerByteStrobeOut = strobeOut_q;
  assign upperByteStrobeOut = strobeOut_q;
  assign lowerByteStrobeOeN = strobeOeN_q;
  assign upperByteStrobeOeN = strobeOeN_q;

  // write engine, replaced by any new access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      wrIdx_q[0] <= 4'h0;
      wrIdx_q[1] <= 4'h0;
    end else if (isWr) begin
      wr_q <= newBurst;
      wrIdx_q[0] <= 4'h0;
      wrIdx_q[1] <= 4'h0;
    end else if (isRd || wrDone || state_q != ST_RUN) begin
      wr_q.active <= 1'b0;
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (laneTake[l]) begin
          wrIdx_q[l] <= 4'(wrIdx_q[l] + 4'h1);
        end
      end
    end
  end

  // masked bytes skip the array; no reset on storage
  always_ff @(posedge sys_clk) begin
    if (laneTake[0] && !dataNow.mask[0] && !isWr && !isRd) begin
      memArr[wrAddrLo][0] <= dataNow.dq[7:0];
    end
    if (laneTake[1] && !dataNow.mask[1] && !isWr && !isRd) begin
      memArr[wrAddrHi][1] <= dataNow.dq[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      refRow_q <= 14'h0000;
      srCnt_q <= 16'h0000;
    end else if (state_q == ST_SELFREF) begin
      if (srCnt_q >= 16'(srInterval - 16'h1)) begin
        srCnt_q <= 16'h0000;
        refRow_q <= nextRefRow(refRow_q, areaCode);
      end else begin
        srCnt_q <= 16'(srCnt_q + 16'h1);
      end
    end else begin
      srCnt_q <= 16'h0000;
      if (isRef) begin
        refRow_q <= nextRefRow(refRow_q, areaCode);
      end
    end
  end

endmodule

// >>> test/lpddr_core_props.sv
module lpddr_core_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankSelect,
  input wire logic [11:0] addr,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic [15:0] dqOut,
  input wire logic dqOeN,
  input wire logic lowerByteStrobeOut,
  input wire logic upperByteStrobeOut,
  input wire logic lowerByteStrobeOeN,
  input wire logic upperByteStrobeOeN,
  input wire logic [2:0] outputDriveStrength
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic strobePrev_q;
  logic [3:0] words_q;
  logic [3:0] words_d;
  // a read command raises dqOeN, so chained reads restart the count; the bench never chains them
  assign words_d = dqOeN ? 4'h0 : words_q + 4'(lowerByteStrobeOut != strobePrev_q);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strobePrev_q <= 1'b0;
      words_q <= 4'h0;
    end else begin
      strobePrev_q <= lowerByteStrobeOut;
      words_q <= words_d;
    end
  end
  property p_ack_pulse;
    wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_lat;
    wbCyc && wbStb && !wbAck |=> wbAck;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_lanes;
    lowerByteStrobeOut == upperByteStrobeOut && lowerByteStrobeOeN == upperByteStrobeOeN;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane strobes differ");
  property p_oe_pair;
    !dqOeN |-> !lowerByteStrobeOeN;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("data without strobe");
  property p_preamble;
    $fell(dqOeN) |-> $past(!lowerByteStrobeOeN) && lowerByteStrobeOut;
  endproperty
  a_preamble: assert property (p_preamble) else $error("no strobe preamble");
  property p_word_edge;
    !dqOeN && $past(!dqOeN) && $changed(dqOut) |-> $changed(lowerByteStrobeOut);
  endproperty
  a_word_edge: assert property (p_word_edge) else $error("word off strobe edge");
  property p_word_stands;
    !dqOeN && $stable(lowerByteStrobeOut) |-> $stable(dqOut);
  endproperty
  a_word_stands: assert property (p_word_stands) else $error("word changed early");
  property p_drive_cfg;
    $changed(outputDriveStrength) |-> !csN && !rasN && !casN && !weN &&
      bankSelect == 2'h2 && outputDriveStrength == addr[7:5];
  endproperty
  a_drive_cfg: assert property (p_drive_cfg) else $error("drive changed alone");
  property p_burst_len;
    words_q <= 4'h8;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst too long");
endmodule

bind lpddr_core lpddr_core_props props (.sys_clk(sys_clk), .rstn(rstn), .csN(csN),
  .rasN(rasN), .casN(casN), .weN(weN), .bankSelect(bankSelect), .addr(addr),
  .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .dqOut(dqOut), .dqOeN(dqOeN),
  .lowerByteStrobeOut(lowerByteStrobeOut), .upperByteStrobeOut(upperByteStrobeOut),
  .lowerByteStrobeOeN(lowerByteStrobeOeN), .upperByteStrobeOeN(upperByteStrobeOeN),
  .outputDriveStrength(outputDriveStrength));

// >>> test/host_ctrl.sv
module host_ctrl import lpddr_core_pkg::*; (
  input wire logic sys_clk,
  output logic timingPairT,
  output logic timingPairC,
  output cmdPins_t c,
  output dataPins_t d
);
  timeunit 1ns;
  timeprecision 100ps;
  int edgeCnt = 0;
  int cmdEdge = 0;
  assign timingPairC = ~timingPairT;
  // pair runs free; stopping it is only optional
  initial begin
    timingPairT = 1'b0;
    c = {1'b1, 1'b1, 3'b111, 2'h0, 12'h000};
    d = '0;
    #7;
    forever #32 timingPairT = ~timingPairT;
  end
  always @(timingPairT) edgeCnt++;
  // order set by the caller
  // pins set in the low phase, held across the rising crossing
  task automatic cmd(input cmdPins_t v);
    @(negedge timingPairT);
    @(posedge sys_clk);
    c <= v;
    @(posedge timingPairT);
    #1 cmdEdge = edgeCnt;
    @(negedge timingPairT);
    @(posedge sys_clk);
    c <= {v.cke, 1'b0, 3'b111, v.bank, v.addr};
  endtask
  task automatic wr(input logic [127:0] w, input logic [15:0] m, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      d.dq <= w[16*i +: 16];
      d.mask <= m[2*i +: 2];
      repeat (3) @(posedge sys_clk);
      d.strobe <= ~d.strobe;
      repeat (2) @(posedge sys_clk);
    end
    // released data shows the inverse, not a held copy
    d.dq <= ~d.dq;
  endtask
endmodule

// >>> test/testbench.sv
module testbench import lpddr_core_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rstn, pairT, pairC, dqOeN, lso, uso, lsoe, usoe, wbCyc, wbStb, wbWe, wbAck, il;
  cmdPins_t c;
  dataPins_t d;
  logic [15:0] dqOut, mem [512], rdQ [$], m;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDatI, wbDatO, r;
  logic [2:0] drive, bl, cl, dv;
  logic [8:0] s;
  logic [127:0] w;
  int failures = 0;
  int n_compared = 0;
  int seed = 10;
  int firstLat, len;
  logic prevS = 1'b0;
  wire [15:0] dqWire = !dqOeN ? dqOut : d.dq;
  wire lsWire = !lsoe ? lso : d.strobe[0];
  wire usWire = !usoe ? uso : d.strobe[1];
  initial forever #2.5 sys_clk = ~sys_clk;
  host_ctrl host (.sys_clk(sys_clk), .timingPairT(pairT), .timingPairC(pairC), .c(c), .d(d));
  lpddr_core #(.MEM_BITS(12), .SR_BASE(8)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .timingPairT(pairT), .timingPairC(pairC), .cke(c.cke), .csN(c.csN), .rasN(c.rasN),
    .casN(c.casN), .weN(c.weN), .bankSelect(c.bank), .addr(c.addr), .dqIn(dqWire),
    .dqOut(dqOut), .dqOeN(dqOeN), .lowerByteStrobeIn(lsWire), .upperByteStrobeIn(usWire),
    .lowerByteStrobeOut(lso), .upperByteStrobeOut(uso), .lowerByteStrobeOeN(lsoe),
    .upperByteStrobeOeN(usoe), .lowerWriteMask(d.mask[0]), .upperWriteMask(d.mask[1]),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .outputDriveStrength(drive));
  // words taken on every strobe edge while the device drives
  always @(negedge sys_clk) begin
    if (dqOeN === 1'b0 && lso !== prevS) begin
      if (rdQ.size() == 0) firstLat = host.edgeCnt - host.cmdEdge;
      rdQ.push_back(dqOut);
    end
    prevS = lso;
  end
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wbx(input logic we, input logic [3:0] a, input logic [31:0] v);
    int i;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= v;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 50) failures++;
    if (i == 50) results();
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic statusIs(input logic [3:0] banks, input logic [1:0] st);
    wbx(1'b0, 4'h4, 32'h0);
    check({26'h0, r[7:6], r[3:0]}, {26'h0, st, banks});
  endtask
  task automatic waitWords(input int n);
    int i;
    for (i = 0; i < 400 && rdQ.size() < n; i++) @(posedge sys_clk);
    if (i == 400) failures++;
    if (i == 400) results();
    repeat (40) @(posedge sys_clk);
  endtask
  function automatic cmdPins_t mk(input logic [2:0] op, input logic [1:0] b,
      input logic [11:0] a, input logic k = 1'b1, input logic cs = 1'b0);
    return {k, cs, op, b, a};
  endfunction
  function automatic logic [8:0] at(input int i);
    logic [8:0] msk;
    msk = 9'(len - 1);
    return il ? ((s & ~msk) | ((s ^ 9'(i)) & msk)) : ((s & ~msk) | ((s + 9'(i)) & msk));
  endfunction
  initial begin
    rstn = 1'b0;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = {3'h0, 4'h0, 4'hf, 32'h0};
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    check({26'h0, dqOeN, lsoe, wbAck, drive}, 32'h30);
    repeat (3) @(posedge sys_clk);
    wbx(1'b1, 4'h8, 32'h0);
    wbx(1'b0, 4'h8, 32'h0);
    check(r, 32'h032);
    wbx(1'b0, 4'h2, 32'h0);
    check(r, 32'h0);
    wbx(1'b1, 4'h0, 32'h6);
    wbx(1'b0, 4'h0, 32'h0);
    check(r, 32'h6);
    for (int a = 0; a < 5; a++) begin
      dv = 3'($random(seed));
      host.cmd(mk(3'b000, 2'h2, {4'h0, dv, 2'b00, 3'(a)}));
      check({29'h0, drive}, {29'h0, dv});
      wbx(1'b0, 4'hc, 32'h0);
      check(r, {24'h0, dv, 2'b00, 3'(a)});
    end
    host.cmd(mk(3'b011, 2'h0, 12'h000));
    host.cmd(mk(3'b011, 2'h2, 12'h005));
    host.cmd(mk(3'b011, 2'h1, 12'h000, 1'b1, 1'b1));
    statusIs(4'b0101, 2'h0);
    host.cmd(mk(3'b010, 2'h2, 12'h000));
    statusIs(4'b0001, 2'h0);
    for (int k = 0; k < 12; k++) begin
      bl = 3'(k % 3 + 1);
      il = 1'((k / 3) % 2);
      cl = 3'(2 + k / 6);
      len = 1 << bl;
      s = 9'($random(seed));
      host.cmd(mk(3'b010, 2'h0, 12'h400));
      host.cmd(mk(3'b000, 2'h0, {5'h0, cl, il, bl}));
      wbx(1'b0, 4'h8, 32'h0);
      check(r, {25'h0, cl, il, bl});
      host.cmd(mk(3'b011, 2'h0, 12'h000));
      // second pass masks random bytes over the first
      for (int p = 0; p < 2; p++) begin
        w = {$random(seed), $random(seed), $random(seed), $random(seed)};
        m = p == 0 ? 16'h0 : 16'($random(seed));
        host.cmd(mk(3'b100, 2'h0, {3'h0, s}));
        host.wr(w, m, len);
        for (int i = 0; i < len; i++) begin
          if (!m[2*i]) mem[at(i)][7:0] = w[16*i +: 8];
          if (!m[2*i+1]) mem[at(i)][15:8] = w[16*i+8 +: 8];
        end
      end
      rdQ.delete();
      host.cmd(mk(3'b101, 2'h0, {3'h0, s}));
      waitWords(len);
      check(32'(rdQ.size()), 32'(len));
      check(32'(firstLat), 32'(2 * cl));
      foreach (rdQ[i])
        check({16'h0, rdQ[i]}, {16'h0, mem[at(i)]});
    end
    rdQ.delete();
    host.cmd(mk(3'b101, 2'h0, {3'h0, s}));
    host.cmd(mk(3'b110, 2'h0, 12'h000));
    repeat (150) @(posedge sys_clk);
    // terminate lands before the first word, so nothing comes out
    check(32'(rdQ.size()), 32'h0);
    rdQ.delete();
    host.cmd(mk(3'b101, 2'h0, {3'h2, s}));
    host.cmd(mk(3'b110, 2'h0, 12'h000));
    waitWords(8);
    check(32'(rdQ.size()), 32'h8);
    statusIs(4'b0000, 2'h0);
    host.cmd(mk(3'b011, 2'h1, 12'h000));
    host.cmd(mk(3'b011, 2'h3, 12'h0ff));
    host.cmd(mk(3'b001, 2'h0, 12'h000));
    statusIs(4'b1010, 2'h0);
    host.cmd(mk(3'b010, 2'h1, 12'h400));
    statusIs(4'b0000, 2'h0);
    host.cmd(mk(3'b001, 2'h0, 12'h000, 1'b0));
    host.cmd(mk(3'b011, 2'h0, 12'h000, 1'b0));
    statusIs(4'b0000, 2'h1);
    host.cmd(mk(3'b111, 2'h0, 12'h000));
    statusIs(4'b0000, 2'h0);
    wbx(1'b1, 4'h0, 32'h7);
    host.cmd(mk(3'b110, 2'h0, 12'h000, 1'b0));
    statusIs(4'b0000, 2'h2);
    host.cmd(mk(3'b111, 2'h0, 12'h000));
    wbx(1'b0, 4'h4, 32'h0);
    check({31'h0, r[8]}, 32'h1);
    host.cmd(mk(3'b000, 2'h0, 12'h032));
    wbx(1'b0, 4'h4, 32'h0);
    check({31'h0, r[8]}, 32'h0);
    results();
  end
endmodule
